// file: logic/pfch_map.svh
`ifndef PFCH_MAP_SVH
`define PFCH_MAP_SVH

// ----------------------------------------------------------------
// byte offsets of the configuration header
// ----------------------------------------------------------------
`define PFCH_OFS_IDENT 8'h00
`define PFCH_OFS_COMMAND 8'h04
`define PFCH_OFS_STATUS 8'h06
`define PFCH_OFS_REVISION 8'h08
`define PFCH_OFS_CLASS 8'h09
`define PFCH_OFS_HEADER 8'h0E
`define PFCH_OFS_SELF_TEST 8'h0F
`define PFCH_OFS_BOARD_VENDOR 8'h2C
`define PFCH_OFS_BOARD_PRODUCT 8'h2E

// ----------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------
`define PFCH_CMD_IO_BIT 0
`define PFCH_CMD_MEM_BIT 1
`define PFCH_CMD_MASTER_BIT 2
`define PFCH_CMD_SPECIAL_BIT 3
`define PFCH_CMD_PERR_RESP_BIT 6
`define PFCH_CMD_RESET 16'h0003

// ----------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------
`define PFCH_STAT_FIXED_LO 7'h10
`define PFCH_STAT_FAST_B2B_BIT 7
`define PFCH_STAT_MASTER_PERR_BIT 8
`define PFCH_STAT_DEVSEL_LO 9
`define PFCH_STAT_SIG_TABORT_BIT 11
`define PFCH_STAT_RCV_TABORT_BIT 12
`define PFCH_STAT_RCV_MABORT_BIT 13
`define PFCH_STAT_SIG_SERR_BIT 14
`define PFCH_STAT_DET_PERR_BIT 15
`define PFCH_STAT_RESET 16'h0210

// ----------------------------------------------------------------
// fixed identification values
// ----------------------------------------------------------------
`define PFCH_CLASS_CODE 24'h060100
`define PFCH_HEADER_TYPE 8'h80
`define PFCH_SELF_TEST 8'h00

`endif

// file: logic/pfch_pkg.sv
package pfch_pkg;

   // device-select timing code
   typedef enum logic [1:0] {
      PFCH_DEVSEL_FAST = 2'h0,
      PFCH_DEVSEL_MEDIUM = 2'h1,
      PFCH_DEVSEL_SLOW = 2'h2,
      PFCH_DEVSEL_RSVD = 2'h3
   } pfch_devsel_t;

   typedef logic [31:0] pfch_dword_t;
   typedef logic [15:0] pfch_half_t;

endpackage

// file: logic/pfch_sticky_flag.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// error flag: set by hardware, cleared only by reset
// ----------------------------------------------------------------
module pfch_sticky_flag #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_set,
   output logic o_flag_q
);

   logic flag_d;

   assign flag_d = o_flag_q | i_set;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_flag_q <= RESET_VAL;
      end else begin
         o_flag_q <= flag_d;
      end
   end

endmodule

// file: logic/pfch_config_header.sv
// How it works
// - command bit 6 read-write parity response enable, reset 0
// - command resets 0003h; bits 15:7, 5:4 and 2 read zero
// - command bit 3 special-cycle response reads 0, writes ignored
// - command bit 1 memory decode always reads 1, always responds
// - command bit 0 I/O decode always reads 1, always responds
// - status bit 15 set on address or data phase parity error
// - status bit 14 set when system error signalled
// - status bit 13 set on master-abort, never for special cycles
// - status bit 12 set when target-abort received
// - status bit 11 always reads 0
// - status resets 0210h; select timing bits 10:9 read 01b medium
// - status bit 8 set on master parity error only if bit 6 enabled
// - status bit 7 always reads 0, no fast back-to-back
// - status bits 6:0 read 10h; software must not program them
// - read-only revision byte at 08h, writes ignored
// - read-only class code 060100h at 0B-09h
// - read-only header type 80h at 0Eh, multi-function
// - read-only self-test byte at 0Fh reads 00h
// - subsystem vendor and subsystem identifiers read-only at 2Ch, 2Eh
// - offsets 0C-0Dh, 10-2Bh, 30-3Fh reserved
`timescale 1ns/1ns
`include "pfch_map.svh"

module pfch_config_header
   import pfch_pkg::*;
#(
   // identity values arbitrary
   parameter logic [7:0] SILICON_REVISION = 8'h3C,
   parameter logic [15:0] BOARD_VENDOR_ID = 16'h5A5A,
   parameter logic [15:0] BOARD_PRODUCT_ID = 16'hA5C3
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_cfg_valid,
   input wire logic i_cfg_write,
   input wire logic [3:0] i_cfg_index,
   input wire logic [3:0] i_cfg_be,
   input wire logic [31:0] i_cfg_wdata,
   input wire logic i_parity_err_detected,
   input wire logic i_serr_signalled,
   input wire logic i_master_abort,
   input wire logic i_special_cycle,
   input wire logic i_target_abort_rcvd,
   input wire logic i_master_perr,
   output logic o_cfg_ack,
   output logic [31:0] o_cfg_rdata,
   output logic o_parity_resp_en,
   output logic o_mem_space_en,
   output logic o_io_space_en
);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_IDENT = `PFCH_OFS_IDENT;
   localparam logic [7:0] OFS_COMMAND = `PFCH_OFS_COMMAND;
   localparam logic [7:0] OFS_REVISION = `PFCH_OFS_REVISION;
   localparam logic [7:0] OFS_HEADER = `PFCH_OFS_HEADER;
   localparam logic [7:0] OFS_BOARD = `PFCH_OFS_BOARD_VENDOR;
   localparam logic [15:0] CMD_RESET = `PFCH_CMD_RESET;

   wire logic hit_ident;
   wire logic hit_cmd_stat;
   wire logic hit_rev_class;
   wire logic hit_header;
   wire logic hit_board;
   wire logic cfg_rd;
   wire logic cfg_wr;
   wire logic cmd_low_wr;

   assign hit_ident = (i_cfg_index == OFS_IDENT[5:2]);
   assign hit_cmd_stat = (i_cfg_index == OFS_COMMAND[5:2]);
   assign hit_rev_class = (i_cfg_index == OFS_REVISION[5:2]);
   assign hit_header = (i_cfg_index == OFS_HEADER[5:2]);
   assign hit_board = (i_cfg_index == OFS_BOARD[5:2]);
   assign cfg_rd = i_cfg_valid & ~i_cfg_write;
   assign cfg_wr = i_cfg_valid & i_cfg_write;
   // only byte 0 of the command word holds a writable bit
   assign cmd_low_wr = cfg_wr & hit_cmd_stat & i_cfg_be[0];

   // ----------------------------------------------------------------
   // command word
   // ----------------------------------------------------------------
   logic perr_resp_q;
   logic perr_resp_d;
   logic mem_en_q;
   logic io_en_q;
   pfch_half_t cmd_word;

   assign perr_resp_d = cmd_low_wr ? i_cfg_wdata[`PFCH_CMD_PERR_RESP_BIT]
                                   : perr_resp_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         perr_resp_q <= CMD_RESET[`PFCH_CMD_PERR_RESP_BIT];
         mem_en_q <= 1'b1;
         io_en_q <= 1'b1;
      end else begin
         perr_resp_q <= perr_resp_d;
         mem_en_q <= 1'b1;
         io_en_q <= 1'b1;
      end
   end

   // decode bits hardwired on; master and special-cycle bits hardwired off
   assign cmd_word = {9'h000, perr_resp_q, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1};

   // ----------------------------------------------------------------
   // status error flags
   // ----------------------------------------------------------------
   wire logic set_det_perr;
   wire logic set_sig_serr;
   wire logic set_rcv_mabort;
   wire logic set_rcv_tabort;
   wire logic set_master_perr;
   logic det_perr_q;
   logic sig_serr_q;
   logic rcv_mabort_q;
   logic rcv_tabort_q;
   logic master_perr_q;
   pfch_devsel_t devsel_code;
   pfch_half_t stat_word;

   assign set_det_perr = i_parity_err_detected;
   assign set_sig_serr = i_serr_signalled;
   assign set_rcv_mabort = i_master_abort & ~i_special_cycle;
   assign set_rcv_tabort = i_target_abort_rcvd;
   assign set_master_perr = i_master_perr & perr_resp_q;
   assign devsel_code = PFCH_DEVSEL_MEDIUM;

   pfch_sticky_flag #(
      .RESET_VAL(1'b0)
   ) u_det_perr (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_set(set_det_perr),
      .o_flag_q(det_perr_q)
   );

   pfch_sticky_flag #(
      .RESET_VAL(1'b0)
   ) u_sig_serr (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_set(set_sig_serr),
      .o_flag_q(sig_serr_q)
   );

   pfch_sticky_flag #(
      .RESET_VAL(1'b0)
   ) u_rcv_mabort (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_set(set_rcv_mabort),
      .o_flag_q(rcv_mabort_q)
   );

   pfch_sticky_flag #(
      .RESET_VAL(1'b0)
   ) u_rcv_tabort (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_set(set_rcv_tabort),
      .o_flag_q(rcv_tabort_q)
   );

   pfch_sticky_flag #(
      .RESET_VAL(1'b0)
   ) u_master_perr (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_set(set_master_perr),
      .o_flag_q(master_perr_q)
   );

   // never signals target-abort, no fast back-to-back as target
   assign stat_word = {det_perr_q, sig_serr_q, rcv_mabort_q, rcv_tabort_q,
                       1'b0, devsel_code, master_perr_q, 1'b0,
                       `PFCH_STAT_FIXED_LO};

   // ----------------------------------------------------------------
   // read data selection
   // ----------------------------------------------------------------
   wire pfch_dword_t dw_cmd_stat;
   wire pfch_dword_t dw_rev_class;
   wire pfch_dword_t dw_header;
   wire pfch_dword_t dw_board;
   wire pfch_dword_t rdata_sel;

   assign dw_cmd_stat = {stat_word, cmd_word};
   assign dw_rev_class = {`PFCH_CLASS_CODE, SILICON_REVISION};
   assign dw_header = {`PFCH_SELF_TEST, `PFCH_HEADER_TYPE, 16'h0000};
   assign dw_board = {BOARD_PRODUCT_ID, BOARD_VENDOR_ID};

   // identification word and reserved dwords read zero here
   assign rdata_sel = hit_cmd_stat ? dw_cmd_stat :
                      hit_rev_class ? dw_rev_class :
                      hit_header ? dw_header :
                      hit_board ? dw_board :
                      32'h00000000;

   // ----------------------------------------------------------------
   // answer registers
   // ----------------------------------------------------------------
   pfch_dword_t rdata_d;

   assign rdata_d = cfg_rd ? rdata_sel : 32'h00000000;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cfg_ack <= 1'b0;
         o_cfg_rdata <= 32'h00000000;
      end else begin
         o_cfg_ack <= i_cfg_valid;
         o_cfg_rdata <= rdata_d;
      end
   end

   assign o_parity_resp_en = perr_resp_q;
   assign o_mem_space_en = mem_en_q;
   assign o_io_space_en = io_en_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_read_cmd;
      cfg_rd && hit_cmd_stat;
   endsequence

   sequence s_read_rev;
      cfg_rd && hit_rev_class;
   endsequence

   sequence s_read_hdr;
      cfg_rd && hit_header;
   endsequence

   sequence s_write_perr(logic v);
      cmd_low_wr && (i_cfg_wdata[`PFCH_CMD_PERR_RESP_BIT] == v);
   endsequence

   chk_perr_resp_write: assert property (
      s_write_perr(1'b1) |=> o_parity_resp_en)
      else $error("parity response bit not written");

   chk_perr_resp_read: assert property (
      s_read_cmd |=> (o_cfg_rdata[`PFCH_CMD_PERR_RESP_BIT] == $past(o_parity_resp_en)))
      else $error("parity response bit misread");

   chk_perr_resp_clear: assert property (
      s_write_perr(1'b0) |=> !o_parity_resp_en)
      else $error("parity response bit not cleared");

   chk_cmd_zero_bits: assert property (
      s_read_cmd |=> (o_cfg_rdata[15:7] == 9'h000) && (o_cfg_rdata[5:4] == 2'h0)
                     && !o_cfg_rdata[2] && o_cfg_ack)
      else $error("command reserved bits not zero");

   chk_special_off: assert property (
      s_read_cmd |=> !o_cfg_rdata[`PFCH_CMD_SPECIAL_BIT])
      else $error("special cycle bit set");

   chk_mem_decode_on: assert property (
      (cfg_wr && hit_cmd_stat) |=> o_mem_space_en [*2])
      else $error("memory decode dropped");

   chk_io_decode_on: assert property (
      s_read_cmd |=> o_cfg_rdata[`PFCH_CMD_IO_BIT] && o_cfg_rdata[`PFCH_CMD_MEM_BIT]
                     && o_io_space_en)
      else $error("decode bits not one");

   chk_det_perr_set: assert property (
      i_parity_err_detected ##[1:8] s_read_cmd |=> o_cfg_rdata[16 + `PFCH_STAT_DET_PERR_BIT])
      else $error("detected parity flag missing");

   chk_serr_set: assert property (
      i_serr_signalled ##[1:8] s_read_cmd |=> o_cfg_rdata[16 + `PFCH_STAT_SIG_SERR_BIT])
      else $error("system error flag missing");

   chk_mabort_special: assert property (
      (!rcv_mabort_q && i_master_abort && i_special_cycle) |=> !rcv_mabort_q)
      else $error("special cycle set master-abort flag");

   chk_mabort_set: assert property (
      (i_master_abort && !i_special_cycle) |=> rcv_mabort_q)
      else $error("master-abort flag missing");

   chk_tabort_set: assert property (
      i_target_abort_rcvd ##[1:8] s_read_cmd |=> o_cfg_rdata[16 + `PFCH_STAT_RCV_TABORT_BIT])
      else $error("target-abort flag missing");

   chk_stat_fixed: assert property (
      s_read_cmd |=> !o_cfg_rdata[16 + `PFCH_STAT_SIG_TABORT_BIT]
                     && !o_cfg_rdata[16 + `PFCH_STAT_FAST_B2B_BIT])
      else $error("status fixed-zero bits set");

   chk_devsel_medium: assert property (
      s_read_cmd |=> (o_cfg_rdata[26:25] == 2'h1))
      else $error("select timing not medium");

   chk_master_perr_gate: assert property (
      (!master_perr_q && i_master_perr && !o_parity_resp_en) |=> !master_perr_q)
      else $error("master parity flag set while disabled");

   chk_master_perr_set: assert property (
      (i_master_perr && o_parity_resp_en) |=> master_perr_q)
      else $error("master parity flag missing");

   chk_stat_low_bits: assert property (
      s_read_cmd |=> (o_cfg_rdata[22:16] == 7'h10) && !o_cfg_rdata[23])
      else $error("status low bits wrong");

   chk_rev_class: assert property (
      s_read_rev |=> (o_cfg_rdata == {24'h060100, SILICON_REVISION}))
      else $error("revision or class wrong");

   chk_header_self_test_byte: assert property (
      s_read_hdr |=> (o_cfg_rdata == 32'h00800000))
      else $error("header or self-test wrong");

   chk_board_ids: assert property (
      (cfg_rd && hit_board) |=> (o_cfg_rdata == {BOARD_PRODUCT_ID, BOARD_VENDOR_ID}))
      else $error("subsystem identifiers wrong");

   chk_reserved_zero: assert property (
      (cfg_rd && !hit_cmd_stat && !hit_rev_class && !hit_header && !hit_board)
      |=> (o_cfg_rdata == 32'h00000000))
      else $error("reserved location not zero");

   chk_ident_zero: assert property (
      (cfg_rd && hit_ident) |=> (o_cfg_rdata == 32'h00000000))
      else $error("identification word not zero");

   chk_flags_sticky: assert property (
      (det_perr_q && sig_serr_q) |=> $stable(det_perr_q) && $stable(sig_serr_q))
      else $error("error flag cleared without reset");

   chk_ack_timing: assert property (
      i_cfg_valid |=> o_cfg_ack ##1 (o_cfg_ack == $past(i_cfg_valid)))
      else $error("answer strobe late");

endmodule

// file: tb/pfch_host_model.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// host bridge side: one configuration access per call
// ----------------------------------------------------------------
module pfch_host_model (
   input wire logic i_clk,
   input wire logic i_ack,
   input wire logic [31:0] i_rdata,
   output logic o_valid,
   output logic o_write,
   output logic [3:0] o_index,
   output logic [3:0] o_be,
   output logic [31:0] o_wdata
);
   initial begin
      o_valid = 1'b0;
      o_write = 1'b0;
      o_index = 4'h0;
      o_be = 4'h0;
      o_wdata = 32'h0;
   end

   // no answer within the bound leaves unknown data
   task automatic access(input logic w, input logic [7:0] ofs, input logic [3:0] b,
         input logic [31:0] d, output logic [31:0] q);
      q = 'x;
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_write <= w;
      o_index <= ofs[5:2];
      o_be <= (ofs[5:2] == 4'h1) ? (b & 4'h3) : b;
      o_wdata <= d;
      @(posedge i_clk);
      o_valid <= 1'b0;
      for (int n = 0; n < 4; n++) begin
         @(posedge i_clk);
         if (i_ack === 1'b1) begin
            q = i_rdata;
            break;
         end
      end
   endtask
endmodule

// file: tb/pfch_config_header_test.sv
`timescale 1ns/1ns

module pfch_config_header_test;
   // arbitrary identity values
   localparam logic [7:0] REV = 8'h2B;
   localparam logic [15:0] BVEN = 16'h1357;
   localparam logic [15:0] BPRD = 16'h2468;
   logic clk, rst_n, valid, wr, ack, perr_en, mem_en, io_en;
   logic [3:0] idx, be;
   logic [31:0] wdata, rdata;
   logic [5:0] ev;
   int err_count, comparisons;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   pfch_config_header #(.SILICON_REVISION(REV), .BOARD_VENDOR_ID(BVEN),
         .BOARD_PRODUCT_ID(BPRD)) u_pfch_config_header (
      .i_clk(clk), .i_rst_n(rst_n), .i_cfg_valid(valid), .i_cfg_write(wr),
      .i_cfg_index(idx), .i_cfg_be(be), .i_cfg_wdata(wdata),
      .i_parity_err_detected(ev[0]), .i_serr_signalled(ev[1]),
      .i_master_abort(ev[2]), .i_special_cycle(ev[3]),
      .i_target_abort_rcvd(ev[4]), .i_master_perr(ev[5]),
      .o_cfg_ack(ack), .o_cfg_rdata(rdata), .o_parity_resp_en(perr_en),
      .o_mem_space_en(mem_en), .o_io_space_en(io_en));

   pfch_host_model u_pfch_host_model (
      .i_clk(clk), .i_ack(ack), .i_rdata(rdata), .o_valid(valid),
      .o_write(wr), .o_index(idx), .o_be(be), .o_wdata(wdata));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask

   task automatic rd_chk(input string what, input logic [7:0] ofs, input logic [31:0] exp);
      logic [31:0] d;
      u_pfch_host_model.access(1'b0, ofs, 4'h0, 32'h0, d);
      chk(what, exp, d);
   endtask

   task automatic wr_cfg(input logic [7:0] ofs, input logic [3:0] b, input logic [31:0] d);
      logic [31:0] q;
      u_pfch_host_model.access(1'b1, ofs, b, d, q);
   endtask

   task automatic pulse(input logic [5:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 6'h0;
   endtask

   task automatic chk_en(input logic p, input logic m, input logic i);
      chk("parity_en", {31'h0, p}, {31'h0, perr_en});
      chk("mem_en", {31'h0, m}, {31'h0, mem_en});
      chk("io_en", {31'h0, i}, {31'h0, io_en});
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_vals;
      rd_chk("status_command", 8'h04, 32'h0210_0003);
      chk_en(1'b0, 1'b1, 1'b1);
   endtask

   task automatic t_command;
      wr_cfg(8'h04, 4'h1, 32'hFFFF_FFFF);
      rd_chk("command_ones", 8'h04, 32'h0210_0043);
      chk_en(1'b1, 1'b1, 1'b1);
      wr_cfg(8'h04, 4'hE, 32'h0);
      rd_chk("command_no_be0", 8'h04, 32'h0210_0043);
      wr_cfg(8'h04, 4'h1, 32'h0);
      rd_chk("command_zero", 8'h04, 32'h0210_0003);
      chk_en(1'b0, 1'b1, 1'b1);
   endtask

   task automatic t_ident;
      rd_chk("class_rev", 8'h08, {24'h060100, REV});
      wr_cfg(8'h08, 4'hF, 32'hFFFF_FFFF);
      rd_chk("class_rev_wr", 8'h08, {24'h060100, REV});
      wr_cfg(8'h0C, 4'hF, 32'hFFFF_FFFF);
      rd_chk("hdr_selftest", 8'h0C, 32'h0080_0000);
      wr_cfg(8'h2C, 4'hF, 32'hFFFF_FFFF);
      rd_chk("board_ids", 8'h2C, {BPRD, BVEN});
   endtask

   task automatic t_reserved;
      for (int i = 0; i < 16; i++) begin
         if (!(i inside {1, 2, 3, 11})) begin
            wr_cfg(8'(i * 4), 4'hF, 32'hFFFF_FFFF);
            rd_chk("reserved", 8'(i * 4), 32'h0);
         end
      end
   endtask

   task automatic t_events;
      pulse(6'h20);
      rd_chk("perr_gated", 8'h04, 32'h0210_0003);
      pulse(6'h0C);
      rd_chk("special_abort", 8'h04, 32'h0210_0003);
      pulse(6'h01);
      rd_chk("det_parity", 8'h04, 32'h8210_0003);
      pulse(6'h02);
      rd_chk("sys_error", 8'h04, 32'hC210_0003);
      pulse(6'h04);
      rd_chk("master_abort", 8'h04, 32'hE210_0003);
      pulse(6'h10);
      rd_chk("target_abort", 8'h04, 32'hF210_0003);
      wr_cfg(8'h04, 4'h1, 32'h40);
      pulse(6'h20);
      rd_chk("master_perr", 8'h04, 32'hF310_0043);
      wr_cfg(8'h04, 4'hF, 32'hFFFF_FFFF);
      rd_chk("flags_held", 8'h04, 32'hF310_0043);
   endtask

   task automatic t_rerst;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk("after_reset", 8'h04, 32'h0210_0003);
      chk_en(1'b0, 1'b1, 1'b1);
   endtask

   task automatic close_out;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      ev = 6'h0;
      err_count = 0;
      comparisons = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_vals();
      t_command();
      t_ident();
      t_reserved();
      t_events();
      t_rerst();
      close_out();
   end

   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      close_out();
   end
endmodule
